// file: rtl/lsd_params.svh
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH

// register byte offsets
`define LSD_CTRL_OFS 12'h000
`define LSD_STATUS_OFS 12'h004
// control field positions and reset values
`define LSD_CTRL_DLY_LSB 0
`define LSD_CTRL_DLY_MSB 15
`define LSD_CTRL_EN_BIT 16
`define LSD_CTRL_EN_RST 1'b1
// status field positions
`define LSD_ST_LATCH_LSB 0
`define LSD_ST_SHIFT_LSB 8
`define LSD_ST_FAULT_BIT 16
`define LSD_ST_MAP_LSB 24
// timing: settle time after the gate opens, before the sinks are judged
`define LSD_CLK_NS 4
`define LSD_CHECK_NS 300
`define LSD_CHECK_CYC ((`LSD_CHECK_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS)

`endif

// file: rtl/lsd_pkg.sv
package lsd_pkg;
  // open-circuit check sequencer, one bit changes on each step except judge back to idle
  typedef enum logic [1:0] {
    LSD_IDLE = 2'b00,
    LSD_SETTLE = 2'b01,
    LSD_JUDGE = 2'b11
  } lsd_check_e;

  // software control word
  typedef struct packed {
    logic check_en;
    logic [15:0] check_dly;
  } lsd_ctrl_s;

  // synchronised link pins
  typedef struct packed {
    logic sclk;
    logic din;
    logic latch_load;
    logic gate_n;
  } lsd_link_s;
endpackage

// file: rtl/lsd_driver.sv
`timescale 1ns/10ps
`include "lsd_params.svh"

module lsd_driver import lsd_pkg::*; #(
  parameter int WIDTH = 8
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link pins
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic latch_load,
  input wire logic output_gate_n,
  output logic serial_out,
  // led sinks, open drain: pulled low while enabled
  input wire logic [WIDTH-1:0] sink_current,
  output logic [WIDTH-1:0] led_sink_channels,
  output logic [WIDTH-1:0] led_sink_channels_oe
);

  lsd_link_s link_meta;
  lsd_link_s link_sync;
  lsd_link_s link_prev;
  logic [WIDTH-1:0] sense_meta;
  logic [WIDTH-1:0] sense_sync;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] next_shift;
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] next_data;
  logic [WIDTH-1:0] open_map;
  logic [31:0] rd_word;
  logic ctrl_hit;
  logic status_hit;
  logic settle_done;
  logic judge;
  logic gate_open;
  logic [WIDTH-1:0] out_latch;
  logic [WIDTH-1:0] fault_map;
  logic fault;
  lsd_ctrl_s ctrl;
  lsd_check_e check_state;
  logic [15:0] settle_cnt;
  logic sclk_rise;
  logic load_rise;
  logic gate_fall;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // true when the byte address selects the control register
  function automatic logic lsd_is_ctrl(input logic [11:0] addr);
    lsd_is_ctrl = (addr == `LSD_CTRL_OFS);
  endfunction

  // true when the byte address selects the status register
  function automatic logic lsd_is_status(input logic [11:0] addr);
    lsd_is_status = (addr == `LSD_STATUS_OFS);
  endfunction

  // one serial step: the word moves up one place, the new bit enters at the bottom
  function automatic logic [WIDTH-1:0] lsd_shift(input logic [WIDTH-1:0] word, input logic din);
    lsd_shift = {word[WIDTH-2:0], din};
  endfunction

  // channels told to sink that see no current; idle channels never count
  function automatic logic [WIDTH-1:0] lsd_open(input logic [WIDTH-1:0] latch,
    input logic [WIDTH-1:0] sense);
    lsd_open = latch & ~sense;
  endfunction

  // link pin synchroniser; the gate resets closed to match its idle level,
  // otherwise a quiet gate pin would look like a fall right after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_meta <= '{sclk: 1'b0, din: 1'b0, latch_load: 1'b0, gate_n: 1'b1};
      link_sync <= '{sclk: 1'b0, din: 1'b0, latch_load: 1'b0, gate_n: 1'b1};
    end else begin
      link_meta <= '{sclk: serial_clk, din: serial_in, latch_load: latch_load,
                     gate_n: output_gate_n};
      link_sync <= link_meta; // only this stage is read
    end
  end

  // current sense synchroniser; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_meta <= '0;
      sense_sync <= '0;
    end else begin
      sense_meta <= sink_current;
      sense_sync <= sense_meta;
    end
  end

  // edge history; gate resets high so a held-low gate looks like a fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_prev <= '{sclk: 1'b0, din: 1'b0, latch_load: 1'b0, gate_n: 1'b1};
    end else begin
      link_prev <= link_sync;
    end
  end

  // edges and levels of the synchronised pins
  assign sclk_rise = link_sync.sclk & ~link_prev.sclk;
  assign load_rise = link_sync.latch_load & ~link_prev.latch_load;
  assign gate_open = ~link_sync.gate_n;
  assign gate_fall = gate_open & link_prev.gate_n;

  // shift then, on load rise, stamp the fault pair; the gate plays no part
  always_comb begin
    next_shift = shift_reg;
    if (sclk_rise) begin
      next_shift = lsd_shift(shift_reg, link_sync.din);
    end
    if (load_rise) begin
      next_shift[6] = fault;
      next_shift[5] = fault;
    end
  end

  // display copy of the word: shifts alike but never takes the fault stamp,
  // so a reported fault cannot switch channels five and six on or off
  always_comb begin
    next_data = data_reg;
    if (sclk_rise) begin
      next_data = lsd_shift(data_reg, link_sync.din);
    end
  end

  // shift register; its top bit is the serial output for cascading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= next_shift;
    end
  end

  // display word register; only the latch reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= '0;
    end else begin
      data_reg <= next_data;
    end
  end

  // top bit drives the cascade output
  assign serial_out = shift_reg[WIDTH-1];

  // transparent latch, takes the display word in the same cycle as the shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch <= '0;
    end else if (link_sync.latch_load) begin
      out_latch <= next_data;
    end
  end
  // with load low the latch simply keeps its value, which covers the fall

  // sink drive: a one in the latch pulls the pin low while the gate is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_sink_channels_oe <= '0;
    end else if (gate_open) begin
      led_sink_channels_oe <= out_latch;
    end else begin
      led_sink_channels_oe <= '0;
    end
  end

  // open drain: the pin level never moves, the enable carries the state
  assign led_sink_channels = '0;

  // the count starts at zero, so the sinks get check_dly + 1 cycles to settle
  assign settle_done = (settle_cnt >= ctrl.check_dly);
  assign judge = (check_state == LSD_JUDGE);

  // open-circuit check: wait for the sinks to settle, then judge once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_state <= LSD_IDLE;
      settle_cnt <= '0;
    end else begin
      case (check_state)
        LSD_IDLE: begin
          if (gate_fall && ctrl.check_en) begin
            check_state <= LSD_SETTLE;
            settle_cnt <= '0;
          end
        end
        LSD_SETTLE: begin
          if (link_sync.gate_n) begin
            check_state <= LSD_IDLE; // gate closed early, no valid reading
          end else if (settle_done) begin
            check_state <= LSD_JUDGE;
          end else begin
            settle_cnt <= settle_cnt + 16'h0001;
          end
        end
        LSD_JUDGE: begin
          check_state <= LSD_IDLE;
        end
        default: begin
          check_state <= LSD_IDLE;
        end
      endcase
    end
  end

  // open channels as they stand now; only the judge cycle keeps them
  assign open_map = lsd_open(out_latch, sense_sync);

  // per-channel map for software, refreshed by each completed check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_map <= '0;
    end else if (judge) begin
      fault_map <= open_map;
    end
  end

  // fault result stands until the next completed check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault <= 1'b0;
    end else if (judge) begin
      fault <= |open_map;
    end
  end

  // apb decode; zero wait states, so pready is tied high
  assign ctrl_hit = lsd_is_ctrl(paddr);
  assign status_hit = lsd_is_status(paddr);
  assign addr_ok = ctrl_hit | status_hit;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // control register steers the check sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '{check_en: `LSD_CTRL_EN_RST, check_dly: 16'(`LSD_CHECK_CYC)};
    end else if (wr_en && ctrl_hit) begin
      ctrl.check_en <= pwdata[`LSD_CTRL_EN_BIT];
      ctrl.check_dly <= pwdata[`LSD_CTRL_DLY_MSB:`LSD_CTRL_DLY_LSB];
    end
  end

  // read word of the addressed register; unmapped reads give zero
  always_comb begin
    rd_word = '0;
    if (ctrl_hit) begin
      rd_word[`LSD_CTRL_EN_BIT] = ctrl.check_en;
      rd_word[`LSD_CTRL_DLY_MSB:`LSD_CTRL_DLY_LSB] = ctrl.check_dly;
    end else if (status_hit) begin
      rd_word[`LSD_ST_LATCH_LSB +: 8] = out_latch;
      rd_word[`LSD_ST_SHIFT_LSB +: 8] = shift_reg;
      rd_word[`LSD_ST_FAULT_BIT] = fault;
      rd_word[`LSD_ST_MAP_LSB +: 8] = fault_map;
    end
  end

  // read data captured in setup so it comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= rd_word;
    end
  end

endmodule

// file: verif/lsd_host_model.sv
`timescale 1ns/10ps
module lsd_host_model #(
  parameter int HALF = 20
) (
  // system clock paces the link
  input wire logic pclk,
  // link pins
  output logic serial_clk,
  output logic serial_in,
  output logic latch_load,
  output logic output_gate_n,
  input wire logic serial_out
);
  // idle pins: link clock low, sinks gated off
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    latch_load = 1'b0;
    output_gate_n = 1'b1;
  end
  // one word, msb first; the returned bit is taken just before each rise
  task automatic xfer(input logic [7:0] w, output logic [7:0] back);
    for (int i = 7; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (HALF) @(posedge pclk);
      back[i] = serial_out;
      serial_clk <= 1'b1;
      repeat (HALF) @(posedge pclk);
      serial_clk <= 1'b0;
    end
  endtask
  // load pulse only once every bit is in
  task automatic pulse_load();
    latch_load <= 1'b1;
    repeat (HALF) @(posedge pclk);
    latch_load <= 1'b0;
    repeat (HALF) @(posedge pclk);
  endtask
  // long dwell so the open check finishes before anything else moves
  task automatic set_gate(input logic g);
    output_gate_n <= g;
    repeat (2 * HALF) @(posedge pclk);
  endtask
endmodule

// file: verif/lsd_driver_checker.sv
`timescale 1ns/10ps
`include "lsd_params.svh"
module lsd_driver_checker #(
  parameter int WIDTH = 8
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link and sinks
  input wire logic serial_clk,
  input wire logic latch_load,
  input wire logic output_gate_n,
  input wire logic serial_out,
  input wire logic [WIDTH-1:0] led_sink_channels,
  input wire logic [WIDTH-1:0] led_sink_channels_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answers at once, errors only off the map
  AST_READY: assert property (psel && penable |-> pready) else $error("pready low");
  AST_ERR: assert property (psel && penable |-> pslverr ==
    !(paddr == `LSD_CTRL_OFS || paddr == `LSD_STATUS_OFS)) else $error("pslverr wrong");
  AST_ERR_RD: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data");
  // open drain sinks: level always low, enable carries the state
  AST_SINK_LOW: assert property (led_sink_channels == '0) else $error("sink level");
  AST_OFF: assert property (output_gate_n [*5] |-> led_sink_channels_oe == '0)
    else $error("sink on while gated");
  AST_RISE: assert property ($rose(output_gate_n) |-> ##[1:5] led_sink_channels_oe == '0)
    else $error("gate rise missed");
  // quiet load and gate: shifting alone never disturbs the sinks
  AST_HOLD: assert property ((!latch_load && $stable(output_gate_n)) [*8]
    |=> $stable(led_sink_channels_oe)) else $error("latch moved");
  AST_SOUT: assert property (($stable(serial_clk) && $stable(latch_load)) [*6]
    |=> $stable(serial_out)) else $error("serial out moved");
  C_SINK: cover property (led_sink_channels_oe != '0);
  C_SOUT: cover property ($rose(serial_out));
  C_ERR: cover property (pslverr && psel && penable);
endmodule
bind lsd_driver lsd_driver_checker #(.WIDTH(WIDTH)) chk_u (.*);

// file: verif/lsd_driver_tb.sv
`timescale 1ns/10ps
`include "lsd_params.svh"
module lsd_driver_tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, serial_clk, serial_in, latch_load, output_gate_n, serial_out;
  logic [7:0] sink_current, led_sink_channels_oe, open_mask;
  int mismatches = 0, num_checks = 0;
  always #2 pclk = ~pclk;
  // led loads: current flows on each sinking channel unless its led is open
  always @(posedge pclk) sink_current <= led_sink_channels_oe & ~open_mask;
  lsd_driver #(.WIDTH(8)) dut_u (.*, .led_sink_channels());
  lsd_host_model host_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, watchdog covers a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    apb(1'b0, `LSD_CTRL_OFS, '0, rd, err);
    chk(rd, 32'h0001004B);
    apb(1'b1, `LSD_CTRL_OFS, 32'h00010010, rd, err);
    apb(1'b0, `LSD_CTRL_OFS, '0, rd, err);
    chk(rd, 32'h00010010);
    apb(1'b0, 12'h008, '0, rd, err);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  // the first of two words in a row comes back whole, eight clocks late
  task automatic t_chain();
    logic [7:0] b;
    host_u.xfer(8'hA5, b);
    chk({24'h0, b}, 32'h00);
    host_u.xfer(8'h9A, b);
    chk({24'h0, b}, 32'hA5);
  endtask
  // load while gated, then open the gate
  task automatic t_latch();
    logic [7:0] b;
    host_u.pulse_load();
    chk({24'h0, led_sink_channels_oe}, 32'h00);
    host_u.set_gate(1'b0);
    chk({24'h0, led_sink_channels_oe}, 32'h9A);
    host_u.xfer(8'h71, b);
    chk({24'h0, b}, 32'h9A);
    chk({24'h0, led_sink_channels_oe}, 32'h9A);
  endtask
  // open led on channel 0: ignored while off, flagged once commanded
  task automatic t_fault();
    logic [7:0] b;
    logic [31:0] rd;
    logic err;
    open_mask <= 8'h01;
    host_u.set_gate(1'b1);
    host_u.set_gate(1'b0);
    apb(1'b0, `LSD_STATUS_OFS, '0, rd, err);
    chk({23'h0, rd[31:24], rd[16]}, 32'h0);
    host_u.pulse_load();
    chk({24'h0, led_sink_channels_oe}, 32'h71);
    host_u.set_gate(1'b1);
    host_u.set_gate(1'b0);
    host_u.pulse_load();
    chk({24'h0, led_sink_channels_oe}, 32'h71);
    host_u.xfer(8'h00, b);
    chk({24'h0, b}, 32'h71);
    apb(1'b0, `LSD_STATUS_OFS, '0, rd, err);
    chk({23'h0, rd[31:24], rd[16]}, 32'h3);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    open_mask = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_regs();
    t_chain();
    t_latch();
    t_fault();
    print_verdict();
  end
  // the run needs about 1630 cycles; this allows over six times that
  initial begin
    #40000;
    mismatches++;
    print_verdict();
  end
endmodule
